/* amp_mode_pkg.sv */
// Shared constants for the amplifier mode and output controller.
package amp_mode_pkg;

   // System clock rate.
   localparam int CLK_HZ = 10_000_000;

   // Boot and unmute intervals, printed in milliseconds.
   localparam int BOOT_MS   = 15;
   localparam int UNMUTE_MS = 30;
   localparam int BOOT_CYCLES   = BOOT_MS * (CLK_HZ / 1000);
   localparam int UNMUTE_CYCLES = UNMUTE_MS * (CLK_HZ / 1000);
   localparam int TIMER_W       = 20;

   // Transistor switching rates in hertz.
   localparam int FSW_HIGH_HZ = 256_000;
   localparam int FSW_LOW_HZ  = 128_000;

   // Carrier steps per transistor switching period.
   localparam int CARRIER_STEPS = 8;
   localparam int CARRIER_W     = $clog2(CARRIER_STEPS);
   localparam int DIV_W         = 8;
   // Dividers round to nearest; truncating would push the high rate well above its target.
   localparam logic [DIV_W-1:0] DIV_HIGH =
      DIV_W'((CLK_HZ + FSW_HIGH_HZ * CARRIER_STEPS / 2) / (FSW_HIGH_HZ * CARRIER_STEPS) - 1);
   localparam logic [DIV_W-1:0] DIV_LOW =
      DIV_W'((CLK_HZ + FSW_LOW_HZ * CARRIER_STEPS / 2) / (FSW_LOW_HZ * CARRIER_STEPS) - 1);

   // Carrier offsets: the second half-bridge of a load lags by 270 degrees.
   localparam logic [CARRIER_W-1:0] OFFSET_A = CARRIER_W'(0);
   localparam logic [CARRIER_W-1:0] OFFSET_B = CARRIER_W'(CARRIER_STEPS * 3 / 4);

   // Half-bridge output levels.
   localparam logic [1:0] LVL_ZERO = 2'h0;
   localparam logic [1:0] LVL_HALF = 2'h1;
   localparam logic [1:0] LVL_FULL = 2'h2;

   // Sample magnitude that calls for the faster rate and the second stage.
   localparam int LEVEL_THRESH = 2;

   // Control encodings.
   localparam logic MUTE_FROM_PIN   = 1'b0;
   localparam logic MUTE_FROM_REG   = 1'b1;
   localparam logic PROFILE_LOW_PWR = 1'b0;
   localparam logic PROFILE_HI_PERF = 1'b1;

   typedef enum logic [1:0] {ST_SHUTDOWN, ST_BOOT, ST_RUN, ST_STANDBY} mode_e;

endpackage

/* hold_timer.sv */
// Level-armed delay timer: done rises LIMIT edges after arm goes high.
`timescale 1ns/100ps
`default_nettype none
module hold_timer
   import amp_mode_pkg::*;
#(
   parameter int LIMIT = 16,
   parameter int CW    = TIMER_W
)(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic reset_n,
   // Control
   input  wire logic arm,
   output logic      done_q
);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          done_d;

   always_comb begin
      cnt_d = cnt_q;
      if (!arm) begin
         cnt_d = '0;
      end else if (cnt_q != CW'(LIMIT)) begin
         cnt_d = cnt_q + CW'(1);
      end
      done_d = arm && (cnt_d == CW'(LIMIT));
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q  <= '0;
         done_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         done_q <= done_d;
      end
   end

   chk_timer_full_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(done_q) |-> cnt_q == CW'(LIMIT) && $past(arm))
      else $error("Timer finished before its full count.");

   chk_timer_drop: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !arm |=> !done_q)
      else $error("Timer stayed done after arm fell.");

endmodule
`default_nettype wire

/* hb_modulator.sv */
// Two-phase three-level modulator for one half-bridge.
`timescale 1ns/100ps
`default_nettype none
module hb_modulator
   import amp_mode_pkg::*;
#(
   parameter int                   SAMPLE_W = 4,
   parameter logic [CARRIER_W-1:0] OFFSET   = OFFSET_A,
   parameter bit                   INVERT   = 1'b0
)(
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      reset_n,
   // Carrier and control
   input  wire logic [CARRIER_W-1:0]      carrier,
   input  wire logic                      run,
   input  wire logic                      mute,
   input  wire logic signed [SAMPLE_W-1:0] sample,
   // Half-bridge level
   output logic [1:0]                     level_q
);

   localparam int HALF = CARRIER_STEPS / 2;

   logic signed [SAMPLE_W+2:0] ext;
   logic signed [SAMPLE_W+2:0] dsum;
   logic [CARRIER_W:0]         duty;
   logic [CARRIER_W-1:0]       ph1;
   logic [CARRIER_W-1:0]       ph2;
   logic [1:0]                 level_d;

   always_comb begin
      ext  = (SAMPLE_W+3)'(sample);
      // Muting parks the duty at half so the flying capacitors stay balanced.
      if (mute) begin
         ext = '0;
      end
      dsum = (INVERT ? -ext : ext) + (SAMPLE_W+3)'(HALF);
      if (dsum < 0) begin
         duty = '0;
      end else if (dsum > (SAMPLE_W+3)'(CARRIER_STEPS)) begin
         duty = (CARRIER_W+1)'(CARRIER_STEPS);
      end else begin
         duty = dsum[CARRIER_W:0];
      end
      // Two phases half a period apart; their sum gives zero, half or full.
      ph1 = carrier + OFFSET;
      ph2 = ph1 + CARRIER_W'(HALF);
      level_d = LVL_ZERO;
      if (run) begin
         level_d = 2'({1'b0, ph1} < duty) + 2'({1'b0, ph2} < duty);
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         level_q <= LVL_ZERO;
      end else begin
         level_q <= level_d;
      end
   end

   chk_off_no_switch: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !run |=> level_q == LVL_ZERO)
      else $error("Disabled half-bridge is switching.");

   chk_mute_half_duty: assert property (@(posedge sys_clk) disable iff (!reset_n)
      run && mute |=> level_q == LVL_HALF)
      else $error("Muted half-bridge is not at half duty.");

   chk_level_range: assert property (@(posedge sys_clk) disable iff (!reset_n)
      level_q != 2'h3)
      else $error("Half-bridge level out of range.");

endmodule
`default_nettype wire

/* amp_mode_ctrl.sv */
// Mode controller for a two-channel multilevel class-D power stage.
`timescale 1ns/100ps
`default_nettype none
module amp_mode_ctrl
   import amp_mode_pkg::*;
#(
   parameter int BOOT_COUNT   = BOOT_CYCLES,
   parameter int UNMUTE_COUNT = UNMUTE_CYCLES,
   parameter int SAMPLE_W     = 4
)(
   // Clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       reset_n,
   // Control pins
   input  wire logic                       enable_pin,
   input  wire logic                       mute_n_pin,
   input  wire logic                       output_config_strap,
   // Settings write port
   input  wire logic                       cfg_wr,
   input  wire logic [1:0]                 cfg_channel_mute_bits,
   input  wire logic [1:0]                 cfg_channel_off_bits,
   input  wire logic                       cfg_mute_source,
   input  wire logic                       cfg_standby,
   input  wire logic                       cfg_parallel_bridge,
   input  wire logic                       cfg_strap_override_enable,
   input  wire logic                       cfg_power_profile_select,
   // Audio level per channel
   input  wire logic signed [SAMPLE_W-1:0] ch0_sample,
   input  wire logic signed [SAMPLE_W-1:0] ch1_sample,
   // Half-bridge levels
   output logic [1:0]                      ch0_a_level_q,
   output logic [1:0]                      ch0_b_level_q,
   output logic [1:0]                      ch1_a_level_q,
   output logic [1:0]                      ch1_b_level_q,
   // Status
   output logic                            shutdown_q,
   output logic                            ready_q,
   output logic                            standby_q,
   output logic [1:0]                      muted_q,
   output logic                            parallel_bridge_q,
   output logic                            fast_rate_q,
   output logic                            second_stage_q
);

   // Mode state.
   mode_e state_q;
   mode_e state_d;
   logic  boot_done;

   // Settings.
   logic [1:0] channel_mute_bits_q;
   logic [1:0] channel_mute_bits_d;
   logic [1:0] channel_off_bits_q;
   logic [1:0] channel_off_bits_d;
   logic       mute_source_q;
   logic       mute_source_d;
   logic       standby_reg_q;
   logic       standby_reg_d;
   logic       parallel_bridge_reg_q;
   logic       parallel_bridge_reg_d;
   logic       strap_override_enable_q;
   logic       strap_override_enable_d;
   logic       power_profile_select_q;
   logic       power_profile_select_d;
   logic       strap_pbtl_q;
   logic       strap_pbtl_d;

   // Carrier.
   logic [DIV_W-1:0]     div_q;
   logic [DIV_W-1:0]     div_d;
   logic [CARRIER_W-1:0] carrier_q;
   logic [CARRIER_W-1:0] carrier_d;

   // Per-channel control.
   logic [1:0]                 mute_req;
   logic [1:0]                 unmute_done;
   logic [1:0]                 mute_eff;
   logic [1:0]                 run_ch;
   logic                       pbtl;
   logic                       level_high0;
   logic                       level_high1;
   logic                       fast_rate;
   logic                       stage2;
   logic signed [SAMPLE_W-1:0] ch1_drive;

   // Status next values.
   logic       shutdown_d;
   logic       ready_d;
   logic       standby_d;
   logic [1:0] muted_d;

   // Boot timer runs from the rising enable; dropping enable clears it.
   hold_timer #(
      .LIMIT (BOOT_COUNT),
      .CW    (TIMER_W)
   ) u_boot_timer (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .arm     (enable_pin),
      .done_q  (boot_done)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_SHUTDOWN: begin
            if (enable_pin) begin
               state_d = ST_BOOT;
            end
         end
         ST_BOOT: begin
            if (boot_done) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (standby_reg_q) begin
               state_d = ST_STANDBY;
            end
         end
         ST_STANDBY: begin
            if (!standby_reg_q) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_SHUTDOWN;
         end
      endcase
      if (!enable_pin) begin
         state_d = ST_SHUTDOWN;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_SHUTDOWN;
      end else begin
         state_q <= state_d;
      end
   end

   // Settings are writable once booted, including in standby so the host can wake it.
   always_comb begin
      channel_mute_bits_d     = channel_mute_bits_q;
      channel_off_bits_d      = channel_off_bits_q;
      mute_source_d           = mute_source_q;
      standby_reg_d           = standby_reg_q;
      parallel_bridge_reg_d   = parallel_bridge_reg_q;
      strap_override_enable_d = strap_override_enable_q;
      power_profile_select_d  = power_profile_select_q;
      strap_pbtl_d            = strap_pbtl_q;
      if (state_q == ST_SHUTDOWN) begin
         channel_mute_bits_d     = '0;
         channel_off_bits_d      = '0;
         mute_source_d           = MUTE_FROM_PIN;
         standby_reg_d           = 1'b0;
         parallel_bridge_reg_d   = 1'b0;
         strap_override_enable_d = 1'b0;
         power_profile_select_d  = PROFILE_LOW_PWR;
         if (enable_pin) begin
            strap_pbtl_d = !output_config_strap;
         end
      end else if (cfg_wr && (state_q == ST_RUN || state_q == ST_STANDBY)) begin
         channel_mute_bits_d     = cfg_channel_mute_bits;
         channel_off_bits_d      = cfg_channel_off_bits;
         mute_source_d           = cfg_mute_source;
         standby_reg_d           = cfg_standby;
         parallel_bridge_reg_d   = cfg_parallel_bridge;
         strap_override_enable_d = cfg_strap_override_enable;
         power_profile_select_d  = cfg_power_profile_select;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         channel_mute_bits_q     <= '0;
         channel_off_bits_q      <= '0;
         mute_source_q           <= MUTE_FROM_PIN;
         standby_reg_q           <= 1'b0;
         parallel_bridge_reg_q   <= 1'b0;
         strap_override_enable_q <= 1'b0;
         power_profile_select_q  <= PROFILE_LOW_PWR;
         strap_pbtl_q            <= 1'b0;
      end else begin
         channel_mute_bits_q     <= channel_mute_bits_d;
         channel_off_bits_q      <= channel_off_bits_d;
         mute_source_q           <= mute_source_d;
         standby_reg_q           <= standby_reg_d;
         parallel_bridge_reg_q   <= parallel_bridge_reg_d;
         strap_override_enable_q <= strap_override_enable_d;
         power_profile_select_q  <= power_profile_select_d;
         strap_pbtl_q            <= strap_pbtl_d;
      end
   end

   // Mute source and unmute delay; each channel restarts its delay on any new mute.
   always_comb begin
      if (mute_source_q == MUTE_FROM_REG) begin
         mute_req = channel_mute_bits_q;
      end else begin
         mute_req = {2{!mute_n_pin}};
      end
      mute_eff = mute_req | ~unmute_done;
   end

   for (genvar c = 0; c < 2; c++) begin : g_unmute
      hold_timer #(
         .LIMIT (UNMUTE_COUNT),
         .CW    (TIMER_W)
      ) u_unmute_timer (
         .sys_clk (sys_clk),
         .reset_n (reset_n),
         .arm     (!mute_req[c] && state_q == ST_RUN),
         .done_q  (unmute_done[c])
      );
   end

   // Output configuration, level sensing and switching rate.
   always_comb begin
      pbtl = strap_override_enable_q ? parallel_bridge_reg_q : strap_pbtl_q;
      level_high0 = (int'(ch0_sample) >= LEVEL_THRESH) || (int'(ch0_sample) <= -LEVEL_THRESH);
      level_high1 = (int'(ch1_sample) >= LEVEL_THRESH) || (int'(ch1_sample) <= -LEVEL_THRESH);
      if (power_profile_select_q == PROFILE_HI_PERF) begin
         fast_rate = 1'b1;
      end else begin
         fast_rate = level_high0 || (level_high1 && !pbtl);
      end
      // The off bit wins over mute; in parallel mode channel 1 follows stage2 and ignores its own off bit.
      run_ch = {2{state_q == ST_RUN}} & ~channel_off_bits_q;
      stage2 = 1'b0;
      ch1_drive = ch1_sample;
      if (pbtl) begin
         ch1_drive = ch0_sample;
         stage2 = run_ch[0] && level_high0 && !mute_eff[0];
         run_ch[1] = stage2;
      end
      div_d = div_q - DIV_W'(1);
      carrier_d = carrier_q;
      if (div_q == '0) begin
         div_d = fast_rate ? DIV_HIGH : DIV_LOW;
         carrier_d = carrier_q + CARRIER_W'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_q     <= '0;
         carrier_q <= '0;
      end else begin
         div_q     <= div_d;
         carrier_q <= carrier_d;
      end
   end

   // Four half-bridges; B lags A by 270 degrees so the load sees four steps per period.
   hb_modulator #(.SAMPLE_W(SAMPLE_W), .OFFSET(OFFSET_A), .INVERT(1'b0)) u_ch0_a (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .carrier (carrier_q),
      .run     (run_ch[0]),
      .mute    (mute_eff[0]),
      .sample  (ch0_sample),
      .level_q (ch0_a_level_q)
   );
   hb_modulator #(.SAMPLE_W(SAMPLE_W), .OFFSET(OFFSET_B), .INVERT(1'b1)) u_ch0_b (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .carrier (carrier_q),
      .run     (run_ch[0]),
      .mute    (mute_eff[0]),
      .sample  (ch0_sample),
      .level_q (ch0_b_level_q)
   );
   hb_modulator #(.SAMPLE_W(SAMPLE_W), .OFFSET(OFFSET_A), .INVERT(1'b0)) u_ch1_a (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .carrier (carrier_q),
      .run     (run_ch[1]),
      .mute    (pbtl ? mute_eff[0] : mute_eff[1]),
      .sample  (ch1_drive),
      .level_q (ch1_a_level_q)
   );
   hb_modulator #(.SAMPLE_W(SAMPLE_W), .OFFSET(OFFSET_B), .INVERT(1'b1)) u_ch1_b (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .carrier (carrier_q),
      .run     (run_ch[1]),
      .mute    (pbtl ? mute_eff[0] : mute_eff[1]),
      .sample  (ch1_drive),
      .level_q (ch1_b_level_q)
   );

   // Status flags.
   always_comb begin
      shutdown_d = (state_d == ST_SHUTDOWN);
      ready_d    = (state_d == ST_RUN) || (state_d == ST_STANDBY);
      standby_d  = (state_d == ST_STANDBY);
      muted_d    = mute_eff;
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         shutdown_q        <= 1'b1;
         ready_q           <= 1'b0;
         standby_q         <= 1'b0;
         muted_q           <= 2'h3;
         parallel_bridge_q <= 1'b0;
         fast_rate_q       <= 1'b0;
         second_stage_q    <= 1'b0;
      end else begin
         shutdown_q        <= shutdown_d;
         ready_q           <= ready_d;
         standby_q         <= standby_d;
         muted_q           <= muted_d;
         parallel_bridge_q <= pbtl;
         fast_rate_q       <= fast_rate;
         second_stage_q    <= stage2;
      end
   end

   chk_shutdown_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !enable_pin |=> shutdown_q && !ready_q && state_q == ST_SHUTDOWN)
      else $error("Device not shut down while enable is low.");

   chk_boot_to_run: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state_q == ST_BOOT && boot_done && enable_pin |=> state_q == ST_RUN && ready_q)
      else $error("Boot did not finish into normal operation.");

   chk_pin_mute_now: assert property (@(posedge sys_clk) disable iff (!reset_n)
      mute_source_q == MUTE_FROM_PIN && !mute_n_pin |=> muted_q == 2'h3)
      else $error("Pin mute did not act at once.");

   chk_reg_mute_chan: assert property (@(posedge sys_clk) disable iff (!reset_n)
      mute_source_q == MUTE_FROM_REG && channel_mute_bits_q[1] |=> muted_q[1])
      else $error("Channel mute bit ignored.");

   chk_standby_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state_q == ST_STANDBY |=> ch0_a_level_q == LVL_ZERO && ch1_b_level_q == LVL_ZERO)
      else $error("Switching seen in standby.");

   chk_strap_capture: assert property (@(posedge sys_clk) disable iff (!reset_n)
      state_q == ST_SHUTDOWN && enable_pin |=> strap_pbtl_q == !$past(output_config_strap))
      else $error("Strap not sampled at boot.");

   chk_rate_fixed_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
      power_profile_select_q == PROFILE_HI_PERF |=> fast_rate_q)
      else $error("High-performance profile not at the fixed high rate.");

   chk_stage2_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
      pbtl && !level_high0 |=> ch1_a_level_q == LVL_ZERO && ch1_b_level_q == LVL_ZERO)
      else $error("Second stage switching at low signal level.");

endmodule
`default_nettype wire

/* host_model.sv */
// Host model that drives the control pins and the settings write port.
`timescale 1ns/100ps
`default_nettype none
module host_model (
   // Clock and status
   input  wire logic       sys_clk,
   input  wire logic       ready_q,
   // Pins and settings
   output wire logic       enable_pin,
   output wire logic       mute_n_pin,
   output wire logic       output_config_strap,
   output wire logic       cfg_wr,
   output wire logic [8:0] cfg_word
);
   // Levels the host holds on its pins; the tasks below change them.
   logic       enable_lvl;
   logic       mute_n_lvl;
   logic       strap_lvl;
   logic       wr_lvl;
   logic [8:0] word_lvl;
   assign enable_pin          = enable_lvl;
   assign mute_n_pin          = mute_n_lvl;
   assign output_config_strap = strap_lvl;
   assign cfg_wr              = wr_lvl;
   assign cfg_word            = word_lvl;
   initial begin
      enable_lvl = 1'b0;
      mute_n_lvl = 1'b1;
      strap_lvl  = 1'b1;
      wr_lvl     = 1'b0;
      word_lvl   = 9'h000;
   end
   // The strap settles a full cycle before enable rises.
   task automatic power_up(input logic strap);
      strap_lvl = strap;
      @(posedge sys_clk);
      #1 enable_lvl = 1'b1;
   endtask
   task automatic power_down();
      enable_lvl = 1'b0;
   endtask
   task automatic set_mute_pin(input logic v);
      mute_n_lvl = v;
   endtask
   // A real host holds off until boot is over, so writes wait for ready.
   task automatic write_cfg(input logic [8:0] w);
      int n = 0;
      while (ready_q !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         #1 n++;
      end
      word_lvl = w;
      wr_lvl = 1'b1;
      @(posedge sys_clk);
      #1 wr_lvl = 1'b0;
   endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking testbench for the amplifier mode controller.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import amp_mode_pkg::*;
   localparam int BOOT_N = 20;
   localparam int UNMUTE_N = 30;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic enable_pin, mute_n_pin, strap, cfg_wr;
   logic [8:0] cfg_word;
   logic signed [3:0] ch0_sample = 4'sh0;
   logic signed [3:0] ch1_sample = 4'sh0;
   logic [1:0] a0, b0, a1, b1, muted_q;
   logic shutdown_q, ready_q, standby_q, pb_q, fast_q, second_q;
   int fails = 0;
   int check_count = 0;
   always #50 sys_clk = ~sys_clk;
   host_model host_model_inst (.sys_clk(sys_clk), .ready_q(ready_q), .enable_pin(enable_pin),
      .mute_n_pin(mute_n_pin), .output_config_strap(strap), .cfg_wr(cfg_wr),
      .cfg_word(cfg_word));
   amp_mode_ctrl #(.BOOT_COUNT(BOOT_N), .UNMUTE_COUNT(UNMUTE_N), .SAMPLE_W(4))
   amp_mode_ctrl_inst (.sys_clk(sys_clk), .reset_n(reset_n), .enable_pin(enable_pin),
      .mute_n_pin(mute_n_pin), .output_config_strap(strap), .cfg_wr(cfg_wr),
      .cfg_channel_mute_bits(cfg_word[1:0]), .cfg_channel_off_bits(cfg_word[3:2]),
      .cfg_mute_source(cfg_word[4]), .cfg_standby(cfg_word[5]),
      .cfg_parallel_bridge(cfg_word[6]), .cfg_strap_override_enable(cfg_word[7]),
      .cfg_power_profile_select(cfg_word[8]), .ch0_sample(ch0_sample),
      .ch1_sample(ch1_sample), .ch0_a_level_q(a0), .ch0_b_level_q(b0), .ch1_a_level_q(a1),
      .ch1_b_level_q(b1), .shutdown_q(shutdown_q), .ready_q(ready_q), .standby_q(standby_q),
      .muted_q(muted_q), .parallel_bridge_q(pb_q), .fast_rate_q(fast_q),
      .second_stage_q(second_q));
   task automatic check_bit(input string name, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic check_lvl(input string name, input logic [1:0] exp, input logic [1:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic wait_cycles(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic give_verdict();
      if (fails == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic t_boot(input logic s, input logic exp_pb);
      int n = 0;
      host_model_inst.power_up(s);
      wait_cycles(BOOT_N - 4);
      check_bit("ready_early", 1'b0, ready_q);
      while (ready_q !== 1'b1 && n < 12) begin
         wait_cycles(1);
         n++;
      end
      check_bit("ready", 1'b1, ready_q);
      check_bit("shutdown_run", 1'b0, shutdown_q);
      check_bit("strap_mode", exp_pb, pb_q);
      check_bit("standby_dflt", 1'b0, standby_q);
   endtask
   task automatic t_mute_pin();
      wait_cycles(UNMUTE_N + 8);
      check_lvl("idle_level", LVL_HALF, a0);
      ch0_sample = 4'sh7;
      host_model_inst.set_mute_pin(1'b0);
      wait_cycles(2);
      check_lvl("muted_pin", 2'h3, muted_q);
      wait_cycles(2);
      check_lvl("muted_level", LVL_HALF, a0);
      host_model_inst.set_mute_pin(1'b1);
      wait_cycles(UNMUTE_N - 5);
      check_lvl("unmute_hold", 2'h3, muted_q);
      wait_cycles(10);
      check_lvl("unmuted", 2'h0, muted_q);
      check_lvl("full_a", LVL_FULL, a0);
      check_lvl("zero_b", LVL_ZERO, b0);
      check_bit("fast_loud", 1'b1, fast_q);
      ch0_sample = 4'sh0;
      wait_cycles(3);
      check_bit("slow_idle", 1'b0, fast_q);
   endtask
   task automatic t_reg_mute();
      host_model_inst.write_cfg(9'h011);
      host_model_inst.set_mute_pin(1'b0);
      wait_cycles(3);
      check_lvl("reg_mute", 2'h1, muted_q);
      ch1_sample = 4'sh7;
      host_model_inst.write_cfg(9'h01A);
      wait_cycles(3);
      repeat (16) begin
         check_lvl("off_a", LVL_ZERO, a1);
         check_lvl("off_b", LVL_ZERO, b1);
         wait_cycles(1);
      end
      host_model_inst.set_mute_pin(1'b1);
      host_model_inst.write_cfg(9'h000);
      ch1_sample = 4'sh0;
      wait_cycles(1);
   endtask
   task automatic t_standby_profile();
      host_model_inst.write_cfg(9'h020);
      wait_cycles(3);
      check_bit("standby", 1'b1, standby_q);
      check_lvl("standby_lvl", LVL_ZERO, a0);
      host_model_inst.write_cfg(9'h100);
      wait_cycles(3);
      check_bit("woken", 1'b0, standby_q);
      check_bit("fast_hp", 1'b1, fast_q);
   endtask
   task automatic t_bridge();
      host_model_inst.write_cfg(9'h040);
      wait_cycles(3);
      check_bit("no_override", 1'b0, pb_q);
      host_model_inst.write_cfg(9'h0C0);
      wait_cycles(UNMUTE_N + 8);
      check_bit("override", 1'b1, pb_q);
      check_bit("stage_idle", 1'b0, second_q);
      ch0_sample = 4'sh7;
      wait_cycles(4);
      check_bit("stage_loud", 1'b1, second_q);
      ch0_sample = 4'sh0;
      host_model_inst.write_cfg(9'h0A0);
      wait_cycles(2);
      host_model_inst.power_down();
      wait_cycles(3);
      check_bit("shutdown", 1'b1, shutdown_q);
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      wait_cycles(5);
      check_bit("shutdown_idle", 1'b1, shutdown_q);
      check_bit("ready_idle", 1'b0, ready_q);
      check_lvl("shutdown_lvl", LVL_ZERO, a0);
      t_boot(1'b1, 1'b0);
      t_mute_pin();
      t_reg_mute();
      t_standby_profile();
      t_bridge();
      t_boot(1'b0, 1'b1);
      give_verdict();
   end
   // The scenarios need well under a thousand cycles.
   initial begin
      repeat (4000) @(posedge sys_clk);
      fails++;
      give_verdict();
   end
endmodule
`default_nettype wire
